// *** bench/lsm_checker.sv ***
// concurrent checks on the ports of the lcd scan address mapper
// assumes one pclk domain and presetn async active low

`timescale 1ns/10ps

module lsm_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // glass drive
  input wire logic [17:0] row_select,
  input wire logic [17:0] row_active_mask,
  input wire logic [79:0] column_driver_output,
  input wire logic display_blank,
  // analog and clock controls
  input wire logic [4:0] contrast_level,
  input wire logic follower_enable,
  input wire logic osc_enable,
  input wire logic timebase_input_pin_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // drive and blanking
  // ----------------------------------------------------------------
  blank_all_ground_a: assert property (display_blank |->
    row_select == '0 && row_active_mask == '0 &&
    column_driver_output == '0) else $error("outputs live while blank");
  row_in_mask_a: assert property ((row_select & ~row_active_mask) == '0)
    else $error("selected row outside active rows");
  // a new row holds for at least 8 cycles, never a few cycles only
  row_slot_hold_a: assert property ($changed(row_select) &&
    row_select != '0 |=> ($stable(row_select) || display_blank)[*8])
    else $error("row slot too short");
  // new column pattern only appears with the next row
  cols_latched_a: assert property (!display_blank &&
    $past(!display_blank) && $changed(column_driver_output) |->
    $changed(row_select)) else $error("columns changed inside slot");
  // ----------------------------------------------------------------
  // analog controls and bus
  // ----------------------------------------------------------------
  contrast_steps_a: assert property (contrast_level <= 5'h18)
    else $error("contrast beyond 25 steps");
  followers_off_a: assert property (!follower_enable |-> display_blank)
    else $error("followers off while driving");
  ext_clock_a: assert property (timebase_input_pin_sel |-> !osc_enable)
    else $error("oscillator runs with external timebase");
  zero_wait_a: assert property (psel && !penable ##1
    psel && penable |-> pready) else $error("access phase not ready");
  slverr_access_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");

  cover property (!display_blank && row_select[0]);
  cover property (row_select[17]);
  cover property (pslverr);
endmodule // lsm_checker

bind lsm_scan_mapper lsm_checker lsm_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .row_select(row_select),
  .row_active_mask(row_active_mask),
  .column_driver_output(column_driver_output),
  .display_blank(display_blank), .contrast_level(contrast_level),
  .follower_enable(follower_enable), .osc_enable(osc_enable),
  .timebase_input_pin_sel(timebase_input_pin_sel)
);

// *** bench/lsm_glass_model.sv ***
// passive glass: keeps the column pattern seen on each selected row
// assumes one-hot row_select while a row is driven

`timescale 1ns/10ps

module lsm_glass_model (
  // drive from the mapper
  input wire logic pclk,
  input wire logic [17:0] row_select,
  input wire logic [79:0] column_driver_output,
  // picture as seen per physical row
  output logic [79:0] img [18]
);
  // last pattern wins, so the settled slot value is what stays
  always @(posedge pclk) begin
    for (int i = 0; i < 18; i++) begin
      if (row_select[i]) begin
        img[i] <= column_driver_output;
      end
    end
  end
endmodule // lsm_glass_model

// *** bench/testbench.sv ***
// testbench for the lcd scan address mapper, apb register tasks
// assumes the glass model and checker files compile before it

`timescale 1ns/10ps

module testbench;
  import lsm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, last_err, display_blank, follower_enable;
  logic osc_enable, timebase_input_pin_sel;
  logic [17:0] row_select, row_active_mask;
  logic [79:0] column_driver_output;
  logic [79:0] img [18];
  logic [1:0] bias_select;
  logic [4:0] contrast_level;
  int n_errors = 0, num_checks = 0, cycles = 0;

  always #2.5 pclk = ~pclk;

  lsm_scan_mapper lsm_scan_mapper_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .row_select(row_select), .row_active_mask(row_active_mask),
    .column_driver_output(column_driver_output),
    .display_blank(display_blank), .bias_select(bias_select),
    .contrast_level(contrast_level), .follower_enable(follower_enable),
    .osc_enable(osc_enable),
    .timebase_input_pin_sel(timebase_input_pin_sel));
  lsm_glass_model lsm_glass_model_inst (.pclk(pclk),
    .row_select(row_select), .column_driver_output(column_driver_output),
    .img(img));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard: the tests need well under 60k cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [79:0] got, input logic [79:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; request held until pready seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk({48'h0, rd & m}, {48'h0, exp}, what);
  endtask

  // new setup, then two full frames of 18 slots
  task automatic show(input logic [31:0] c);
    wr(OFF_CTRL, c);
    repeat (4000) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(display_blank, 1'b1, "blank after reset");
    chk({bias_select, contrast_level}, 7'h6c, "power reset");
    chk({osc_enable, follower_enable}, 2'b11, "osc reset");
    rdc(OFF_CTRL, 32'h7fff, 32'h5, "ctrl reset");
    $display("test reset done");

    wr(OFF_POWER, 32'h1f);
    rdc(OFF_POWER, 32'h1f, 32'h18, "contrast clamp");
    for (int b = 0; b < 4; b++) begin
      wr(OFF_POWER, {25'h0, b[1:0], 5'h03});
      @(posedge pclk);
      chk(bias_select, b[1:0], "bias ratio");
    end
    rdc(8'h20, 32'hffffffff, 32'h0, "unmapped read");
    chk(last_err, 1'b1, "unmapped error");
    $display("test power done");

    wr(OFF_PTR, 32'h0);
    wr(OFF_DATA, 32'hf5);
    rdc(OFF_PTR, 32'hff, 32'h01, "pointer up");
    wr(OFF_PTR, 32'h81);
    rdc(OFF_DATA, 32'hff, 32'h20, "unwritten ram");
    rdc(OFF_PTR, 32'hff, 32'h80, "pointer down");
    rdc(OFF_DATA, 32'hff, 32'hf5, "ram data");
    $display("test pointer done");

    show(32'h4000);
    chk(row_active_mask, 18'h0000f, "four seg rows");
    chk(img[0][7:0], 8'h4f, "seg row one");
    chk(img[1][7:0], 8'h44, "seg row two");
    for (int s = 1; s < 3; s++) begin
      show(32'h4000 | (s << 3));
      chk(row_active_mask, (18'h3 << (s - 1)) | 18'h3, "seg duty");
    end
    show(32'h4040);
    chk(img[0][79:72], 8'hf2, "reversed columns");
    show(32'h4020);
    chk(img[17][7:0], 8'h4f, "reversed rows");
    $display("test segment done");

    wr(OFF_PTR, 32'h01);
    wr(OFF_DATA, 32'h00);
    wr(OFF_DATA, 32'h30);
    wr(OFF_PTR, 32'h20);
    wr(OFF_DATA, 32'hf5);
    wr(OFF_PTR, 32'h100);
    wr(OFF_DATA, 32'h11);
    show(32'h4004);
    chk(row_active_mask, 18'h007ff, "one text line");
    show(32'h4005);
    chk(row_active_mask, 18'h3ffff, "two text lines");
    chk(img[0][15:0], 16'h0636, "text line one");
    chk(img[8][4:0], 5'h16, "text line two");
    show(32'h4006);
    chk(row_active_mask, 18'h3ffff, "mirrored lines");
    chk(img[8][4:0], 5'h0d, "mirrored font");
    show(32'h4085);
    chk(img[0][15:0], 16'h0236, "font bank one");
    $display("test character done");

    wr(OFF_CTRL, 32'h6005);
    repeat (4) @(posedge pclk);
    chk({display_blank, osc_enable}, 2'b10, "standby");
    chk(column_driver_output, 80'h0, "standby columns");
    show(32'h4005);
    wr(OFF_CTRL, 32'h5005);
    repeat (4) @(posedge pclk);
    chk({display_blank, row_select}, {1'b1, 18'h0}, "sleep");
    wr(OFF_CTRL, 32'h4805);
    repeat (4) @(posedge pclk);
    chk({timebase_input_pin_sel, osc_enable}, 2'b10, "ext clock");
    wr(OFF_CTRL, 32'h0405);
    repeat (4) @(posedge pclk);
    chk(follower_enable, 1'b0, "followers off");
    $display("test power save done");
    complete_run();
  end
endmodule // testbench

// *** rtl/lsm_pkg.sv ***
// lcd scan address mapper: shared constants, register layouts, types
// assumes one 200 MHz pclk domain and an apb register slave

package lsm_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_POWER = 8'h04;
  localparam logic [7:0] OFF_PTR = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // ----------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------
  localparam int NUM_COLS = 80;
  localparam int NUM_ROWS = 18;
  localparam int NUM_DIGITS = 20;
  localparam int SHOWN_DIGITS = 16;
  localparam int DOTS = 5;
  localparam int DOT_ROWS = 8;
  localparam int SEG_GROUP = 4;
  localparam int UFONT_WORDS = 16;
  localparam logic [6:0] SLOT_CYCLES = 7'd96;

  // line-count encodings, bit 2 is character_mode_select
  localparam logic [2:0] LCS_ONE_LINE = 3'b100;
  localparam logic [2:0] LCS_TWO_LINE = 3'b101;
  localparam logic [2:0] LCS_TWO_MIRROR = 3'b110;

  // first fixed-font code per bank: 240 or 192 patterns
  localparam logic [7:0] BANK0_FIRST = 8'h10;
  localparam logic [7:0] BANK1_FIRST = 8'h40;
  // codes below this select the two user fonts
  localparam logic [7:0] UFONT_LIMIT = 8'h10;

  localparam logic [4:0] CONTRAST_MAX = 5'd24;

  // ----------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic disp_en;
    logic standby;
    logic sleep;
    logic ext_clk;
    logic follower_off;
    logic segment_blink_enable;
    logic blink_period_select;
    logic font_bank;
    logic column_scan_direction;
    logic row_scan_direction;
    logic [1:0] seg_duty;
    logic [2:0] line_count_select;
  } lsm_ctrl_s;

  typedef struct packed {
    logic [1:0] bias;
    logic [4:0] contrast;
  } lsm_power_s;

  typedef struct packed {
    logic cursor_en;
    logic user_font_sel;
    logic count_down;
    logic [6:0] address_pointer;
  } lsm_ptr_s;

  localparam lsm_ctrl_s CTRL_RST = '{line_count_select: LCS_TWO_LINE,
                                     seg_duty: 2'h0, default: 1'b0};
  localparam lsm_power_s POWER_RST = '{bias: 2'h3, contrast: 5'h0c};
  localparam lsm_ptr_s PTR_RST = '{address_pointer: 7'h00,
                                   default: 1'b0};

  typedef enum logic {ST_SHIFT, ST_HOLD} lsm_scan_e;

endpackage

// *** rtl/lsm_scan_mapper.sv ***
// lcd scan address mapper: display ram, user font ram, row scan,
// serial column shifting, latching and blanking, behind an apb slave
// assumes pclk at 200 MHz, presetn async active low, apb master
//
// Operation
// - font bank setting picks 240 or 192 fixed 5x8 patterns
// - segment mode skips the fixed font; ram bits drive segments directly
// - two user 5x8 fonts, character mode only
// - refresh reads ram on its own path, apart from bus accesses
// - cursor at pointer; inert when pointer targets user font ram
// - oscillator stops in standby; external timebase selectable
// - 18 rows, 80 columns; unused rows get deselect level
// - columns shift serially through 80 bits, then latch
// - column shift and row order reverse by direction bits
// - all row and column outputs ground when drive off, standby or sleep
// - bias ratio selectable 1/2 to 1/5
// - voltage followers may be switched off while drive unused
// - contrast has 25 steps
// - character lines at 0x00,0x20,0x40,0x60, digits 0x00-0x13
// - line count 100: 1/11 duty, one text line, three segment rows
// - line count 101/110: 1/18 duty, two text lines, two segment rows
// - line count 110 mirrors second line fonts
// - digits 17 to 20 are never shown in character mode; here the segment rows of that mode still show them
// - column direction picks first character pin order
// - segment mode rows map to four ram lines, four columns each
// - column direction picks first segment pin
// - segment duty 1/2 or 1/3 scans only first rows
// - pointer steps by one after each ram access
// - without blink, upper nibble is segment state, lower ignored
// - blink alternates every 32 or 64 frames, normal or inverse
//
// Added by the designer: the placing of the registers and the APB interface to the registers.

`timescale 1ns/10ps

module lsm_scan_mapper
  import lsm_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // glass drive
  output logic [lsm_pkg::NUM_ROWS-1:0] row_select,
  output logic [lsm_pkg::NUM_ROWS-1:0] row_active_mask,
  output logic [lsm_pkg::NUM_COLS-1:0] column_driver_output,
  output logic display_blank,
  // analog and clock controls
  output logic [1:0] bias_select,
  output logic [4:0] contrast_level,
  output logic follower_enable,
  output logic osc_enable,
  output logic timebase_input_pin_sel
);
  import lsm_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // stand-in fixed font: real glyph art lives in a mask rom
  function automatic logic [4:0] font_row(input logic [7:0] code,
                                          input logic [2:0] drow,
                                          input logic bank);
    logic [7:0] first;
    first = bank ? BANK1_FIRST : BANK0_FIRST;
    if (code < first) begin
      font_row = 5'h00;
    end else begin
      font_row = code[4:0] ^ {code[7:6], drow};
    end
  endfunction

  // pointer step, up or down by one, wrapping in its ram
  function automatic logic [6:0] step(input lsm_ptr_s p);
    logic [6:0] n;
    n = p.count_down ? p.address_pointer - 7'd1
                     : p.address_pointer + 7'd1;
    step = p.user_font_sel ? {3'h0, n[3:0]} : n;
  endfunction

  // ----------------------------------------------------------------
  // registers and storage
  // ----------------------------------------------------------------
  lsm_ctrl_s ctrl_q;
  lsm_power_s power_q;
  lsm_ptr_s ptr_q;
  logic [7:0] dram_q [4][NUM_DIGITS];
  logic [4:0] ufont_q [UFONT_WORDS];
  logic [31:0] prdata_q;
  logic pslverr_q;
  lsm_scan_e state_q;
  logic [6:0] bit_cnt_q;
  logic [4:0] row_q;
  logic [6:0] frame_q;
  logic [NUM_COLS-1:0] sr_q;
  logic [NUM_COLS-1:0] col_q;
  logic [NUM_ROWS-1:0] rsel_q;
  logic [NUM_ROWS-1:0] rmask_q;
  logic blank_q;

  logic setup;
  logic access;
  logic ptr_dig_ok;
  logic mux_active;
  logic char_mode;
  logic two_line;
  logic slot_end;
  logic phase;
  logic [4:0] num_rows;
  logic col_bit;
  logic [NUM_ROWS-1:0] row_mask;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign ptr_dig_ok = ptr_q.address_pointer[4:0] < 5'(NUM_DIGITS);
  assign mux_active = ctrl_q.disp_en & ~ctrl_q.standby & ~ctrl_q.sleep;
  assign char_mode = ctrl_q.line_count_select[2];
  assign two_line = ctrl_q.line_count_select != LCS_ONE_LINE;
  assign slot_end = bit_cnt_q == SLOT_CYCLES - 7'd1;
  // blink flips every 32 or 64 frames
  assign phase = ctrl_q.blink_period_select ? frame_q[6]
                                            : frame_q[5];

  // ----------------------------------------------------------------
  // apb slave: no wait states, answer captured in setup
  // ----------------------------------------------------------------
  assign pready = access;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q & access;

  // read data and error captured while the request is set up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
      if (paddr == OFF_CTRL) begin
        prdata_q <= 32'(ctrl_q);
      end else if (paddr == OFF_POWER) begin
        prdata_q <= 32'(power_q);
      end else if (paddr == OFF_PTR) begin
        prdata_q <= 32'(ptr_q);
      end else if (paddr == OFF_DATA) begin
        if (ptr_q.user_font_sel) begin
          prdata_q <= 32'(ufont_q[ptr_q.address_pointer[3:0]]);
        end else if (ptr_dig_ok) begin
          prdata_q <= 32'(dram_q[ptr_q.address_pointer[6:5]]
                                [ptr_q.address_pointer[4:0]]);
        end
      end else if (paddr == OFF_STATUS) begin
        prdata_q <= {15'h0, blank_q, phase, frame_q, 3'h0, row_q};
      end else begin
        pslverr_q <= 1'b1; // unmapped offset
      end
    end
  end

  // control registers, defaults blank the glass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      power_q <= POWER_RST;
    end else if (access && pwrite) begin
      if (paddr == OFF_CTRL) begin
        ctrl_q <= lsm_ctrl_s'(pwdata[$bits(lsm_ctrl_s)-1:0]);
      end else if (paddr == OFF_POWER) begin
        power_q.bias <= pwdata[6:5];
        // 25 steps, values above the top clamp to it
        power_q.contrast <= (pwdata[4:0] > CONTRAST_MAX) ? CONTRAST_MAX
                                                        : pwdata[4:0];
      end
    end
  end

  // address pointer: direct set or step after each data access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= PTR_RST;
    end else if (access && paddr == OFF_PTR && pwrite) begin
      ptr_q <= lsm_ptr_s'(pwdata[$bits(lsm_ptr_s)-1:0]);
    end else if (access && paddr == OFF_DATA) begin
      ptr_q.address_pointer <= step(ptr_q);
    end
  end

  // ram write port, only the bus touches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_q <= '{default: '{default: 8'h20}};
      ufont_q <= '{default: 5'h00};
    end else if (access && pwrite && paddr == OFF_DATA) begin
      if (ptr_q.user_font_sel) begin
        ufont_q[ptr_q.address_pointer[3:0]] <= pwdata[4:0];
      end else if (ptr_dig_ok) begin
        // gaps 0x14-0x1f of each line are not storage
        dram_q[ptr_q.address_pointer[6:5]]
              [ptr_q.address_pointer[4:0]] <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // scan geometry
  // ----------------------------------------------------------------
  // rows per frame from mode and duty
  always_comb begin
    if (char_mode) begin
      num_rows = two_line ? 5'd18 : 5'd11;
    end else begin
      case (ctrl_q.seg_duty)
        2'h1: num_rows = 5'd2;
        2'h2: num_rows = 5'd3;
        default: num_rows = 5'd4;
      endcase
    end
    row_mask = '0;
    for (int i = 0; i < NUM_ROWS; i++) begin
      // unused rows idle at the deselect level
      if (5'(i) < num_rows) begin
        row_mask[ctrl_q.row_scan_direction ? NUM_ROWS-1-i : i] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // column bit for current row and bit position
  // ----------------------------------------------------------------
  // reads ram combinationally from the scan side; a bus write lands
  // at an edge, so a write during the shift can leave a half-updated row in the latch
  always_comb begin
    logic [6:0] c;
    logic [4:0] chr;
    logic [2:0] dot;
    logic [2:0] drow;
    logic [1:0] line;
    logic is_char;
    logic [7:0] code;
    logic [4:0] pat;
    logic [7:0] sdat;
    logic [4:0] sa;
    logic [1:0] sb;
    c = bit_cnt_q;
    chr = 5'(c / 7'(DOTS));
    dot = 3'(c % 7'(DOTS));
    drow = row_q[2:0];
    line = 2'h0;
    is_char = 1'b0;
    sa = 5'(c / 7'(SEG_GROUP));
    sb = c[1:0];
    pat = 5'h00;
    if (char_mode) begin
      if (row_q < 5'd8) begin
        is_char = 1'b1;
      end else if (two_line && row_q < 5'd16) begin
        is_char = 1'b1;
        line = 2'h1;
      end else begin
        // spare lines become segment rows
        line = two_line ? 2'(row_q - 5'd14) : 2'(row_q - 5'd7);
      end
    end else begin
      line = row_q[1:0];
    end
    if (is_char && ctrl_q.line_count_select == LCS_TWO_MIRROR && line == 2'h1) begin
      dot = 3'(DOTS - 1) - dot;
    end
    code = (chr < 5'(NUM_DIGITS)) ? dram_q[line][chr] : 8'h00;
    if (code < UFONT_LIMIT) begin
      pat = ufont_q[{code[0], drow}];
    end else begin
      pat = font_row(code, drow, ctrl_q.font_bank);
    end
    sdat = (sa < 5'(NUM_DIGITS)) ? dram_q[line][sa] : 8'h00;
    col_bit = 1'b0;
    if (is_char) begin
      if (chr < 5'(SHOWN_DIGITS)) begin
        col_bit = pat[3'(DOTS - 1) - dot];
        // cursor cell inverts on blink phase; user font target is inert
        if (ptr_q.cursor_en && !ptr_q.user_font_sel && phase &&
            ptr_q.address_pointer == {line, chr}) begin
          col_bit = ~col_bit;
        end
      end
    end else if (c < 7'(NUM_COLS)) begin
      // fixed font never consulted for segment rows
      if (ctrl_q.segment_blink_enable) begin
        col_bit = phase ? sdat[2'd3 - sb] : sdat[3'd7 - 3'(sb)];
      end else begin
        col_bit = sdat[3'd7 - 3'(sb)];
      end
    end
  end

  // ----------------------------------------------------------------
  // row scan: shift 80 bits, hold, latch at slot end
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_SHIFT;
      bit_cnt_q <= 7'h0;
    end else begin
      bit_cnt_q <= slot_end ? 7'h0 : bit_cnt_q + 7'd1;
      case (state_q)
        ST_SHIFT: begin
          if (bit_cnt_q == 7'(NUM_COLS - 1)) begin
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (slot_end) begin
            state_q <= ST_SHIFT;
          end
        end
        default: state_q <= ST_SHIFT;
      endcase
    end
  end

  // serial column shifter, direction picks the pin end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= '0;
    end else if (state_q == ST_SHIFT) begin
      if (ctrl_q.column_scan_direction) begin
        sr_q <= {sr_q[NUM_COLS-2:0], col_bit};
      end else begin
        sr_q <= {col_bit, sr_q[NUM_COLS-1:1]};
      end
    end
  end

  // row index and frame counter for blink timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_q <= 5'h0;
      frame_q <= 7'h0;
    end else if (slot_end) begin
      if (row_q + 5'd1 >= num_rows) begin
        row_q <= 5'h0;
        frame_q <= frame_q + 7'd1;
      end else begin
        row_q <= row_q + 5'd1;
      end
    end
  end

  // output latch; blanking overrides at once rather than at slot end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_q <= '0;
      rsel_q <= '0;
      rmask_q <= '0;
      blank_q <= 1'b1;
    end else begin
      blank_q <= ~mux_active;
      if (!mux_active) begin
        col_q <= '0;
        rsel_q <= '0;
        rmask_q <= '0;
      end else if (slot_end) begin
        col_q <= sr_q;
        rmask_q <= row_mask;
        rsel_q <= '0;
        // a row left over from a longer mode stays deselected
        if (row_q < num_rows) begin
          rsel_q[ctrl_q.row_scan_direction ? 5'(NUM_ROWS - 1) - row_q
                                           : row_q] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign row_select = rsel_q;
  assign row_active_mask = rmask_q;
  assign column_driver_output = col_q;
  assign display_blank = blank_q;
  assign bias_select = power_q.bias;
  assign contrast_level = power_q.contrast;
  // followers may only drop while the glass is not driven
  assign follower_enable = ~(ctrl_q.follower_off & blank_q);
  // oscillator idles in standby or when an external clock is chosen
  assign osc_enable = ~ctrl_q.standby & ~ctrl_q.ext_clk;
  assign timebase_input_pin_sel = ctrl_q.ext_clk;

endmodule // lsm_scan_mapper
